/* rtl/sram_burst_sleep_parity.sv */
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Control logic of a no-turnaround synchronous static RAM.
module sram_burst_sleep_parity
  import sram_ctl_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic mclk, // 40 MHz clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  // APB slave.
  input wire logic psel, // Select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Write direction.
  input wire logic [11:0] paddr, // Byte address.
  input wire logic [31:0] pwdata, // Write data.
  output logic [31:0] prdata, // Read data.
  output logic pready, // Ready.
  output logic pslverr, // Unmapped address.
  // Controller side, synchronous to mclk.
  input wire logic chipEnable1_n, // Chip enable one, active low.
  input wire logic chipEnable2, // Chip enable two, active high.
  input wire logic chipEnable3_n, // Chip enable three, active low.
  input wire logic clkEnable_n, // Clock enable, high holds the device.
  input wire logic load_or_step_select, // Low loads, high steps.
  input wire logic writeEnable_n, // Low selects write.
  input wire logic [LANES-1:0] byteWrite_n, // Byte write enables, active low.
  input wire logic [ADDR_W-1:0] extAddr, // External address.
  input wire logic [LANES*LANE_W-1:0] dqIn, // Data pins, input side.
  output logic [LANES*LANE_W-1:0] dqOut, // Data pins, output side.
  output logic dqOe, // Data pins driven.
  // Asynchronous straps and sleep pin.
  input wire logic burst_order_strap, // High or open: interleaved.
  input wire logic output_timing_strap, // High or open: pipelined.
  input wire logic parity_sense_strap, // High or open: even parity.
  input wire logic sleep_request, // Asynchronous, active high.
  // Open-drain error pin.
  input wire logic parity_error_flag_n_in, // Shared wire level.
  output logic parity_error_flag_n_out, // Always low.
  output logic parity_error_flag_n_oe, // High pulls the wire low.
  // Memory core port.
  output logic [ADDR_W-1:0] coreRdAddr, // Read address.
  output logic coreRead, // Read strobe.
  input wire logic [LANES*LANE_W-1:0] coreRdata, // Read data, next cycle.
  output logic [ADDR_W-1:0] coreWrAddr, // Write address.
  output logic coreWrite, // Write strobe.
  output logic [LANES-1:0] coreByteEn, // Lanes to write.
  output logic [LANES*LANE_W-1:0] coreWdata // Write data.
);

  localparam int DW = LANES * LANE_W;

  // Strap and sleep pins cross in through two flip-flops.
  logic [3:0] pinSync;
  logic orderInterleaved;
  logic timingPipe;
  logic senseEven;
  logic sleepReq;
  logic wireSync;

  sync_two_ff #(
    .WIDTH(4),
    .RESET_VAL({STRAP_ORDER_RST, STRAP_TIMING_RST, STRAP_SENSE_RST, SLEEP_REQ_RST})
  ) pinSyncU (
    .mclk(mclk),
    .reset_n(reset_n),
    .asyncIn({burst_order_strap, output_timing_strap, parity_sense_strap, sleep_request}),
    .syncOut(pinSync)
  );

  sync_two_ff #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) wireSyncU (
    .mclk(mclk),
    .reset_n(reset_n),
    .asyncIn(parity_error_flag_n_in),
    .syncOut(wireSync)
  );

  assign orderInterleaved = pinSync[3];
  assign timingPipe = pinSync[2];
  assign senseEven = pinSync[1];
  assign sleepReq = pinSync[0];

  // Sleep state machine; it runs regardless of the clock enable.
  sleep_state_t sleepSt_r;
  sleep_state_t sleepSt_nxt;
  logic [1:0] sleepCnt_r;
  logic [1:0] sleepCnt_nxt;

  always_comb begin
    sleepSt_nxt = sleepSt_r;
    sleepCnt_nxt = '0;
    case (sleepSt_r)
      SLP_ACTIVE: begin
        if (sleepReq) sleepSt_nxt = SLP_ENTERING;
      end
      SLP_ENTERING: begin
        if (!sleepReq) begin
          sleepSt_nxt = SLP_ACTIVE;
        end else if (sleepCnt_r == ENTRY_LAST) begin
          sleepSt_nxt = SLP_ASLEEP;
        end else begin
          sleepCnt_nxt = sleepCnt_r + 2'h1;
        end
      end
      SLP_ASLEEP: begin
        if (!sleepReq) sleepSt_nxt = SLP_WAKING;
      end
      SLP_WAKING: begin
        if (sleepReq) begin
          sleepSt_nxt = SLP_ASLEEP;
        end else if (sleepCnt_r == WAKE_LAST) begin
          sleepSt_nxt = SLP_ACTIVE;
        end else begin
          sleepCnt_nxt = sleepCnt_r + 2'h1;
        end
      end
      default: sleepSt_nxt = SLP_ACTIVE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sleepSt_r <= SLP_ACTIVE;
      sleepCnt_r <= '0;
    end else begin
      sleepSt_r <= sleepSt_nxt;
      sleepCnt_r <= sleepCnt_nxt;
    end
  end

  // Asleep, every sequencing register keeps its value, so state survives the nap.
  wire asleep = (sleepSt_r == SLP_ASLEEP);
  wire waking = (sleepSt_r == SLP_WAKING);
  wire operate = !clkEnable_n && !asleep;

  // Command decode.
  wire selected = !chipEnable1_n && chipEnable2 && !chipEnable3_n;
  wire loadCmd = !load_or_step_select;
  wire [LANES-1:0] byteEn = ~byteWrite_n;

  burst_kind_t burstKind_r;
  logic [ADDR_W-1:0] base_r;
  logic [BURST_W-1:0] burstCnt_r;
  logic [LANES-1:0] burstBe_r;
  logic parityEn_r;

  wire burst_kind_t loadKind = !selected ? BK_NONE : (writeEnable_n ? BK_READ : BK_WRITE);
  wire burst_kind_t kindNxt = loadCmd ? loadKind : burstKind_r;
  wire [ADDR_W-1:0] baseNxt = (loadCmd && selected) ? extAddr : base_r;
  // Two-bit count wraps by itself after the fourth address.
  wire [BURST_W-1:0] cntNxt = loadCmd ? '0 :
    ((burstKind_r != BK_NONE) ? burstCnt_r + 2'h1 : burstCnt_r);
  wire [BURST_W-1:0] lowLinear = baseNxt[BURST_W-1:0] + cntNxt;
  wire [BURST_W-1:0] lowInterleaved = baseNxt[BURST_W-1:0] ^ cntNxt;
  wire [ADDR_W-1:0] accessAddr = {baseNxt[ADDR_W-1:BURST_W],
    orderInterleaved ? lowInterleaved : lowLinear};
  // Continue cycles keep the byte enables sampled on that edge.
  wire [LANES-1:0] accessBe = byteEn;
  // Writes during recovery are dropped; reads are served normally.
  wire doRead = operate && (kindNxt == BK_READ);
  wire doWrite = operate && (kindNxt == BK_WRITE) && !waking;

  // Burst state, held under clock enable hold and sleep.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      burstKind_r <= BK_NONE;
      base_r <= '0;
      burstCnt_r <= '0;
      burstBe_r <= '0;
    end else if (operate) begin
      burstKind_r <= kindNxt;
      base_r <= baseNxt;
      burstCnt_r <= cntNxt;
      burstBe_r <= accessBe;
    end
  end

  // Write command pipeline; data falls due one stage later when pipelined.
  logic wr1Valid_r;
  logic wr2Valid_r;
  logic [ADDR_W-1:0] wr1Addr_r;
  logic [ADDR_W-1:0] wr2Addr_r;
  logic [LANES-1:0] wr1Be_r;
  logic [LANES-1:0] wr2Be_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr1Valid_r <= 1'b0;
      wr2Valid_r <= 1'b0;
      wr1Addr_r <= '0;
      wr2Addr_r <= '0;
      wr1Be_r <= '0;
      wr2Be_r <= '0;
    end else if (operate) begin
      wr1Valid_r <= doWrite;
      wr1Addr_r <= accessAddr;
      wr1Be_r <= accessBe;
      wr2Valid_r <= wr1Valid_r;
      wr2Addr_r <= wr1Addr_r;
      wr2Be_r <= wr1Be_r;
    end
  end

  wire dataDue = timingPipe ? wr2Valid_r : wr1Valid_r;
  wire [ADDR_W-1:0] dueAddr = timingPipe ? wr2Addr_r : wr1Addr_r;
  wire [LANES-1:0] dueBe = timingPipe ? wr2Be_r : wr1Be_r;

  // Per-lane parity over the eight data bits and the parity bit.
  logic [LANES-1:0] laneFail;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gLane
      assign laneFail[g] = ~((^dqIn[g*LANE_W +: LANE_W]) ^ senseEven);
    end
  endgenerate

  // Only write data taken on its due edge is checked, never read data.
  wire errNow = operate && dataDue && parityEn_r && |(laneFail & dueBe);

  // Core write port; a write with no enabled lane is an abort.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      coreWrite <= 1'b0;
      coreWrAddr <= '0;
      coreByteEn <= '0;
      coreWdata <= '0;
    end else begin
      coreWrite <= operate && dataDue && |dueBe;
      if (operate && dataDue) begin
        coreWrAddr <= dueAddr;
        coreByteEn <= dueBe;
        coreWdata <= dqIn;
      end
    end
  end

  // Core read port; the core answers in the following cycle.
  logic [DW-1:0] rdCap_r;

  // The core word is caught even on a held edge, since the strobe drops under hold.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      coreRead <= 1'b0;
      coreRdAddr <= '0;
      rdCap_r <= '0;
    end else begin
      coreRead <= doRead;
      if (doRead) coreRdAddr <= accessAddr;
      if (coreRead) rdCap_r <= coreRdata;
    end
  end

  wire [DW-1:0] rdNow = coreRead ? coreRdata : rdCap_r;

  // Read data path: one stage flow-through, two stages pipelined.
  logic rd1Valid_r;
  logic rd2Valid_r;
  logic [DW-1:0] rd2Data_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd1Valid_r <= 1'b0;
      rd2Valid_r <= 1'b0;
      rd2Data_r <= '0;
    end else if (operate) begin
      rd1Valid_r <= doRead;
      rd2Valid_r <= rd1Valid_r;
      if (rd1Valid_r) rd2Data_r <= rdNow;
    end
  end

  wire dqOeNxt = timingPipe ? rd2Valid_r : rd1Valid_r;
  wire [DW-1:0] dqOutNxt = timingPipe ? rd2Data_r : rdNow;

  // A hold keeps the bus exactly as it was; sleep floats it.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dqOe <= 1'b0;
      dqOut <= '0;
    end else if (asleep) begin
      dqOe <= 1'b0;
    end else if (operate) begin
      dqOe <= dqOeNxt;
      if (dqOeNxt) dqOut <= dqOutNxt;
    end
  end

  // Error reporting: flow-through at the data edge, pipelined one edge later.
  logic errStage_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      errStage_r <= 1'b0;
      parity_error_flag_n_oe <= 1'b0;
      parity_error_flag_n_out <= 1'b0;
    end else if (asleep) begin
      parity_error_flag_n_oe <= 1'b0;
    end else begin
      if (operate) errStage_r <= errNow;
      // The pin only ever sinks, so several flags can share one pull-up.
      parity_error_flag_n_out <= 1'b0;
      if (timingPipe) begin
        parity_error_flag_n_oe <= operate && errStage_r;
      end else begin
        parity_error_flag_n_oe <= errNow;
      end
    end
  end

  // APB decode; the slave answers in the first access cycle.
  wire setupPhase = psel && !penable;
  wire accessDone = psel && penable && pready;
  wire hitCtrl = (paddr == CTRL_OFFS);
  wire hitStatus = (paddr == STATUS_OFFS);
  wire hitErrcnt = (paddr == ERRCNT_OFFS);
  wire mapped = hitCtrl || hitStatus || hitErrcnt;

  logic [ERRCNT_W-1:0] errCnt_r;

  wire [31:0] statusWord = 32'(
    ({30'h0000_0000, sleepSt_r} << ST_SLEEP_LSB) |
    ({31'h0000_0000, orderInterleaved} << ST_ORDER_BIT) |
    ({31'h0000_0000, timingPipe} << ST_TIMING_BIT) |
    ({31'h0000_0000, senseEven} << ST_SENSE_BIT) |
    ({31'h0000_0000, wireSync} << ST_WIRE_BIT) |
    ({30'h0000_0000, burstKind_r} << ST_KIND_LSB) |
    ({30'h0000_0000, burstCnt_r} << ST_CNT_LSB));
  wire [31:0] readMux = hitCtrl ? {31'h0000_0000, parityEn_r} :
    hitStatus ? statusWord :
    hitErrcnt ? {16'h0000, errCnt_r} : 32'h0000_0000;

  // Bus answer registers.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && !mapped;
      if (setupPhase && !pwrite) prdata <= readMux;
    end
  end

  // Control register: parity checking on or off.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      parityEn_r <= CTRL_RST[CTRL_PAR_EN_BIT];
    end else if (accessDone && pwrite && hitCtrl) begin
      parityEn_r <= pwdata[CTRL_PAR_EN_BIT];
    end
  end

  // Error counter saturates; a write clears it, but a new error wins.
  wire cntClear = accessDone && pwrite && hitErrcnt;
  wire cntFull = &errCnt_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      errCnt_r <= '0;
    end else if (cntClear) begin
      errCnt_r <= errNow ? ERRCNT_W'(1) : '0;
    end else if (errNow && !cntFull) begin
      errCnt_r <= errCnt_r + ERRCNT_W'(1);
    end
  end

endmodule

`default_nettype wire

/* common/sram_ctl_pkg.sv */
package sram_ctl_pkg;

  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;

  // Sleep entry and wake intervals, counted in clock cycles.
  localparam int SLEEP_ENTRY_CYCLES = 2;
  localparam int SLEEP_WAKE_CYCLES = 2;
  localparam logic [1:0] ENTRY_LAST = 2'(SLEEP_ENTRY_CYCLES - 1);
  localparam logic [1:0] WAKE_LAST = 2'(SLEEP_WAKE_CYCLES - 1);

  // Strap reset values equal the open-pin defaults.
  localparam logic STRAP_ORDER_RST = 1'b1;
  localparam logic STRAP_TIMING_RST = 1'b1;
  localparam logic STRAP_SENSE_RST = 1'b1;
  localparam logic SLEEP_REQ_RST = 1'b0;

  // APB register map, byte addresses.
  localparam logic [11:0] CTRL_OFFS = 12'h000;
  localparam logic [11:0] STATUS_OFFS = 12'h004;
  localparam logic [11:0] ERRCNT_OFFS = 12'h008;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_PAR_EN_BIT = 0;
  localparam int ERRCNT_W = 16;

  // Status field positions.
  localparam int ST_SLEEP_LSB = 0;
  localparam int ST_ORDER_BIT = 2;
  localparam int ST_TIMING_BIT = 3;
  localparam int ST_SENSE_BIT = 4;
  localparam int ST_WIRE_BIT = 5;
  localparam int ST_KIND_LSB = 6;
  localparam int ST_CNT_LSB = 8;

  typedef enum logic [1:0] {
    SLP_ACTIVE = 2'b00,
    SLP_ENTERING = 2'b01,
    SLP_ASLEEP = 2'b10,
    SLP_WAKING = 2'b11
  } sleep_state_t;

  typedef enum logic [1:0] {
    BK_NONE = 2'b00,
    BK_READ = 2'b01,
    BK_WRITE = 2'b10
  } burst_kind_t;

endpackage

/* rtl/sync_two_ff.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; the first stage is read by the second only.
module sync_two_ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk, // Clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] asyncIn, // Pin levels.
  output logic [WIDTH-1:0] syncOut // Synchronised levels.
);

  logic [WIDTH-1:0] meta_r;

  // Both stages reset to the open-pin default.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule

`default_nettype wire

/* bench/sram_ctl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Timing relations of the controller port, core port and error pin.
module sram_ctl_assertions
  import sram_ctl_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic mclk, // Clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access.
  input wire logic pready, // APB ready.
  input wire logic clkEnable_n, // Hold.
  input wire logic load_or_step_select, // Step when high.
  input wire logic burst_order_strap, // Order strap.
  input wire logic output_timing_strap, // Timing strap.
  input wire logic parity_sense_strap, // Sense strap.
  input wire logic sleep_request, // Sleep pin.
  input wire logic dqOe, // Data driven.
  input wire logic [LANES*LANE_W-1:0] dqOut, // Data out.
  input wire logic [ADDR_W-1:0] coreRdAddr, // Core read address.
  input wire logic coreRead, // Core read.
  input wire logic [LANES*LANE_W-1:0] coreRdata, // Core data.
  input wire logic coreWrite, // Core write.
  input wire logic [LANES-1:0] coreByteEn, // Core lanes.
  input wire logic [LANES*LANE_W-1:0] coreWdata, // Core write data.
  input wire logic parity_error_flag_n_oe // Pin pulled low.
);
  // Straps only move while idle, so their pin level is the level in use.
  function automatic logic badPar(input logic [LANES*LANE_W-1:0] d, input logic [LANES-1:0] en,
                                  input logic s);
    badPar = 1'b0;
    for (int i = 0; i < LANES; i++) badPar |= en[i] && ((^d[i*LANE_W+:LANE_W]) == s);
  endfunction
  wire logic badNow = badPar(coreWdata, coreByteEn, parity_sense_strap);
  wire logic [ADDR_W-1:0] nextLin = {coreRdAddr[ADDR_W-1:2], coreRdAddr[1:0] + 2'h1};
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // A core read that is not held at the edges which move its data to the pins.
  sequence rdFlow;
    coreRead && !clkEnable_n && !output_timing_strap;
  endsequence
  sequence rdPipe;
    coreRead && !clkEnable_n && output_timing_strap ##1 !clkEnable_n;
  endsequence
  a_flag_flow: assert property (
    coreWrite && !output_timing_strap |-> parity_error_flag_n_oe == badNow)
    else $error("flag wrong in flow mode");
  a_flag_pipe: assert property (
    coreWrite && output_timing_strap |=> parity_error_flag_n_oe == $past(badNow))
    else $error("flag wrong in pipe mode");
  a_flag_writes: assert property (
    parity_error_flag_n_oe |-> coreWrite || $past(coreWrite))
    else $error("flag without a write");
  a_read_flow: assert property (
    rdFlow |=> dqOe && dqOut == $past(coreRdata)) else $error("flow read data wrong");
  a_read_pipe: assert property (
    rdPipe |=> dqOe && dqOut == $past(coreRdata, 2)) else $error("pipe read data wrong");
  a_hold_core: assert property (
    clkEnable_n |=> !coreRead && !coreWrite) else $error("core moved while held");
  a_step_linear: assert property (
    coreRead && $past(coreRead) && $past(load_or_step_select) && !$past(clkEnable_n)
    && !burst_order_strap |-> coreRdAddr == $past(nextLin)) else $error("linear step wrong");
  a_sleep_quiet: assert property (
    sleep_request [*6] |-> !dqOe && !coreRead && !coreWrite && !parity_error_flag_n_oe)
    else $error("active while asleep");
  a_apb_ready: assert property (
    psel && !penable |=> pready) else $error("apb ready late");
endmodule
`default_nettype wire

/* bench/core_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Sixteen-word memory core behind the control block.
module core_mem_model
  import sram_ctl_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic mclk, // Clock.
  input wire logic [ADDR_W-1:0] coreRdAddr, // Read address.
  input wire logic coreRead, // Read strobe.
  output logic [LANES*LANE_W-1:0] coreRdata, // Read data.
  input wire logic [ADDR_W-1:0] coreWrAddr, // Write address.
  input wire logic coreWrite, // Write strobe.
  input wire logic [LANES-1:0] coreByteEn, // Lanes.
  input wire logic [LANES*LANE_W-1:0] coreWdata // Write data.
);
  logic [LANES*LANE_W-1:0] mem [16];
  initial foreach (mem[i]) mem[i] = '0;
  // Outside a strobe the word is inverted, so a sample taken late is caught.
  assign coreRdata = coreRead ? mem[coreRdAddr[3:0]] : ~mem[coreRdAddr[3:0]];
  // Only the enabled lanes are written.
  always @(posedge mclk) begin
    for (int i = 0; i < LANES; i++) begin
      if (coreWrite && coreByteEn[i]) mem[coreWrAddr[3:0]][i*LANE_W+:LANE_W] <=
          coreWdata[i*LANE_W+:LANE_W];
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import sram_ctl_pkg::*;
;
  localparam int AW = 18;
  logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, dqOe, coreRead, coreWrite, flagOut, flagOe;
  logic chipEnable1_n = 1'b1, chipEnable2 = 1'b0, chipEnable3_n = 1'b1, clkEnable_n = 1'b0;
  logic load_or_step_select = 1'b0, writeEnable_n = 1'b1, sleep_request = 1'b0;
  logic burst_order_strap = 1'b1, output_timing_strap = 1'b1, parity_sense_strap = 1'b1;
  logic [3:0] byteWrite_n = 4'hF;
  logic [AW-1:0] extAddr = '0, base = '0;
  logic [35:0] dqIn = '0, d1 = '0, d2 = '0;
  wire logic [35:0] dqOut, coreRdata, coreWdata;
  wire logic [3:0] coreByteEn;
  wire logic [AW-1:0] coreRdAddr, coreWrAddr;
  wire logic flagWire = flagOe ? flagOut : 1'b1; // Shared pull-up.
  int n_fail = 0, checks = 0, nerr = 0, nflag = 0;
  logic hp = 1'b0;
  logic [64:0] ae;
  logic [35:0] mirror [16];
  logic [57:0] wq [$];
  logic [35:0] rq [$];
  logic [64:0] aq [$];

  initial forever #12.5 mclk = ~mclk;

  sram_burst_sleep_parity #(.ADDR_W(AW)) u_dut (.mclk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .chipEnable1_n, .chipEnable2, .chipEnable3_n,
    .clkEnable_n, .load_or_step_select, .writeEnable_n, .byteWrite_n, .extAddr, .dqIn, .dqOut,
    .dqOe, .burst_order_strap, .output_timing_strap, .parity_sense_strap, .sleep_request,
    .parity_error_flag_n_in(flagWire), .parity_error_flag_n_out(flagOut),
    .parity_error_flag_n_oe(flagOe), .coreRdAddr, .coreRead, .coreRdata, .coreWrAddr,
    .coreWrite, .coreByteEn, .coreWdata);
  core_mem_model #(.ADDR_W(AW)) u_mem (.mclk, .coreRdAddr, .coreRead, .coreRdata,
    .coreWrAddr, .coreWrite, .coreByteEn, .coreWdata);

  task automatic chk(input string nm, input logic [64:0] seen, input logic [64:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Each result that appears takes the oldest note of its kind; held cycles repeat the pins.
  always @(posedge mclk) begin
    if (reset_n) begin
      if (coreWrite) chk("core write", {coreWrAddr, coreByteEn, coreWdata},
          wq.size() ? wq.pop_front() : 'x);
      if (dqOe && !hp) chk("read data", dqOut,
          rq.size() ? rq.pop_front() : 'x);
      if (psel && penable && pready && !pwrite) begin
        ae = aq.size() ? aq.pop_front() : 'x;
        chk("apb read", {pslverr, prdata & ae[64:33]}, ae[32:0]);
      end
      if (flagOe) nflag++;
    end
    hp = clkEnable_n;
  end

  // One controller cycle; write data trails its command by the mode's latency.
  task automatic op(input logic sel, ld, wr, hold, input logic [3:0] ben,
                    input logic [AW-1:0] a, input logic [35:0] d);
    int ds;
    ds = $urandom_range(2);
    @(posedge mclk);
    clkEnable_n <= hold;
    if (!hold) begin
      chipEnable1_n <= !sel && ds == 0;
      chipEnable2 <= sel || ds != 1;
      chipEnable3_n <= !sel && ds == 2;
      load_or_step_select <= !ld;
      writeEnable_n <= !wr;
      byteWrite_n <= ben;
      extAddr <= a;
      dqIn <= output_timing_strap ? d2 : d1;
      d2 = d1;
      d1 = d;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b1, 1'b0, 1'b0, 4'hF, '0, 36'($urandom()));
  endtask

  // Load plus four steps, the last wrapping to the base; reads get random holds.
  task automatic burst(input logic wr, input logic [AW-1:0] b);
    logic [AW-1:0] a;
    logic [35:0] d;
    logic [3:0] ben;
    int bad;
    for (int c = 0; c < 5; c++) begin
      a = b;
      a[1:0] = burst_order_strap ? b[1:0] ^ 2'(c) : b[1:0] + 2'(c);
      d = {$urandom(), 4'($urandom())};
      for (int i = 0; i < 4; i++) d[i*9+8] = ^d[i*9+:8] ^ !parity_sense_strap;
      ben = wr ? 4'($urandom()) : 4'hF;
      bad = $urandom_range(5);
      if (bad < 4) d[bad*9+8] = ~d[bad*9+8];
      if (wr && ben != 4'hF) begin
        wq.push_back({a, ~ben, d});
        for (int i = 0; i < 4; i++) if (!ben[i]) mirror[a[3:0]][i*9+:9] = d[i*9+:9];
        if (bad < 4 && !ben[bad]) nerr++;
      end
      if (!wr) rq.push_back(mirror[a[3:0]]);
      if (!wr && $urandom_range(2) == 0) op(1'b1, 1'b0, 1'b0, 1'b1, ben, b, d);
      op(1'b1, c == 0, wr, 1'b0, ben, b, d);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] m, v,
                     input logic e);
    if (!wr) aq.push_back({m, e, v});
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Registers, the four strap combinations, then a sleep and wake.
  initial begin
    void'($urandom(87));
    foreach (mirror[i]) mirror[i] = '0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1'b0, CTRL_OFFS, 32'hFFFFFFFF, CTRL_RST, 1'b0);
    apb(1'b0, 12'h00C, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(1'b0, STATUS_OFFS, 32'h3F, 32'h3C, 1'b0);
    apb(1'b1, ERRCNT_OFFS, 32'h0, 32'h0, 1'b0);
    for (int m = 0; m < 4; m++) begin
      output_timing_strap <= m[0];
      burst_order_strap <= m[1];
      parity_sense_strap <= m[0] ^ m[1];
      idle(4);
      base = AW'($urandom());
      burst(1'b1, base);
      idle(3);
      burst(1'b0, base);
      burst(1'b1, base ^ 18'h00004);
      idle(3);
      burst(1'b0, base ^ 18'h00004);
      idle(3);
    end
    sleep_request <= 1'b1;
    idle(6);
    repeat (3) op(1'b1, 1'b1, 1'b1, 1'b0, 4'h0, base, '0);
    idle(1);
    apb(1'b0, STATUS_OFFS, 32'h3, 32'h2, 1'b0);
    sleep_request <= 1'b0;
    idle(6);
    apb(1'b0, STATUS_OFFS, 32'h3, 32'h0, 1'b0);
    burst(1'b1, base);
    idle(3);
    burst(1'b0, base);
    idle(4);
    chk("flag pulses", nflag, nerr);
    apb(1'b0, ERRCNT_OFFS, 32'hFFFF, 32'(nerr), 1'b0);
    idle(3);
    chk("open notes", wq.size() + rq.size() + aq.size(), 0);
    end_sim();
  end

  // Cuts a hang short well beyond the length of the sequence.
  initial begin
    repeat (6000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
endmodule

bind sram_burst_sleep_parity sram_ctl_assertions #(.ADDR_W(ADDR_W)) u_chk (.mclk, .reset_n,
  .psel, .penable, .pready, .clkEnable_n, .load_or_step_select, .burst_order_strap,
  .output_timing_strap, .parity_sense_strap, .sleep_request, .dqOe, .dqOut, .coreRdAddr,
  .coreRead, .coreRdata, .coreWrite, .coreByteEn, .coreWdata, .parity_error_flag_n_oe);
`default_nettype wire
